// [rws_consts.vh]
// Constants for the reset and warm-up sequencer.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef RWS_CONSTS_VH
`define RWS_CONSTS_VH
`define RWS_PC_MCU          16'hfffe
`define RWS_PC_SERIAL       16'h1ffe
`define RWS_SP_RESET        16'h00ff
`define RWS_RBS_RESET       4'h0
`define RWS_IMF_RESET       1'b0
`define RWS_BUS_AW          3
`define RWS_ADDR_CTRL       3'h0
`define RWS_ADDR_STATUS     3'h1
`define RWS_ADDR_CAUSE      3'h2
`define RWS_ADDR_TRIM       3'h3
`define RWS_ADDR_WARMUP     3'h4
`define RWS_CAUSE_W         5
`define RWS_TRIM_W          8
`define RWS_WARMUP_DEFAULT  32'h00000400
`define RWS_SYNC_CLEAR      2'h0
`endif

// [rws_sync.v]
// Two-stage synchroniser for a bundle of asynchronous reset request levels.
// Assumes inputs may change at any time; outputs are clk-synchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "rws_consts.vh"
module rws_sync #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] stage1;

   // Neither stage is cleared during rst_n, so a request is not dropped.
   always @(posedge clk) begin
      stage1   <= async_in;
      sync_out <= stage1;
   end
endmodule
`default_nettype wire

// [rws_sequencer.v]
// Reset and warm-up sequencer: merges reset sources, runs warm-up, loads trim.
// Assumes a trim store that answers a read request, and an Avalon-MM master.
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "rws_consts.vh"
module rws_sequencer #(
   parameter        CNT_W       = 32,
   parameter [31:0] WARMUP_CYC  = `RWS_WARMUP_DEFAULT,
   parameter        NINT        = `RWS_CAUSE_W
) (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   por_req,
   input  wire                   pin_reset_n,
   input  wire                   pin_reset_disable,
   input  wire [NINT-1:0]        internal_req,
   input  wire                   serial_prog_mode,
   output reg                    trim_read,
   input  wire                   trim_valid,
   input  wire [`RWS_TRIM_W-1:0] trim_data,
   input  wire                   trim_abnormal,
   output reg  [`RWS_TRIM_W-1:0] trim_latched,
   output reg                    trim_bad,
   output reg                    cpu_reset,
   output reg                    periph_reset,
   output reg                    cpu_run,
   output reg  [15:0]            program_counter,
   output reg  [15:0]            stack_pointer,
   output reg  [3:0]             register_bank_selector,
   output reg                    interrupt_master_enable,
   output reg                    individual_interrupt_enables_clear,
   output reg                    interrupt_request_latches_clear,
   output reg                    high_freq_osc_enable,
   output reg                    low_freq_osc_enable,
   output reg                    prescaler_clear,
   output reg                    port_hiz,
   output reg                    watchdog_enable,
   output reg                    voltage_detect_disable,
   output reg  [NINT-1:0]        reset_cause_flags,
   input  wire [`RWS_BUS_AW-1:0] avs_address,
   input  wire                   avs_read,
   input  wire                   avs_write,
   input  wire [31:0]            avs_writedata,
   output reg  [31:0]            avs_readdata,
   output wire                   avs_waitrequest
);
   localparam ST_RESET  = 2'h0;
   localparam ST_WARMUP = 2'h1;
   localparam ST_RUN    = 2'h2;

   wire [NINT+1:0] sync_src;
   reg  [1:0]      state;
   reg  [1:0]      next_state;
   reg  [CNT_W-1:0] count;
   reg             trim_done;
   reg             vd_kill;
   reg             acked;
   wire            ext_reset;
   wire            int_reset;
   wire            any_reset;
   wire            warm_end;
   wire            access;

   rws_sync #(.W(NINT + 2)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({internal_req, ~pin_reset_n & ~pin_reset_disable, por_req}),
      .sync_out (sync_src)
   );

   assign ext_reset = sync_src[0] | sync_src[1];
   assign int_reset = |sync_src[NINT+1:2];
   assign any_reset = ext_reset | int_reset | ~rst_n;
   assign warm_end  = (count >= WARMUP_CYC[CNT_W-1:0] - 1'b1) & trim_done;

   always @* begin
      next_state = state;
      case (state)
         ST_RESET:  next_state = ST_WARMUP;
         ST_WARMUP: if (warm_end) next_state = ST_RUN;
         ST_RUN:    next_state = ST_RUN;
         default:   next_state = ST_RESET;
      endcase
      if (any_reset) next_state = ST_RESET;
   end

   // Counter clears in reset, counts in warm-up, freezes after.
   always @(posedge clk) begin
      state <= next_state;
      if (any_reset || state == ST_RESET)
         count <= {CNT_W{1'b0}};
      else if (state == ST_WARMUP && !warm_end)
         count <= count + 1'b1;
   end

   // Trim is fetched once per warm-up; waiting for it keeps the ladder valid at run.
   always @(posedge clk) begin
      if (any_reset) begin
         trim_read <= 1'b0;
         trim_done <= 1'b0;
      end else if (state == ST_WARMUP && !trim_done) begin
         trim_read <= ~trim_valid;
         if (trim_valid) begin
            trim_done    <= 1'b1;
            trim_latched <= trim_data;
            trim_bad     <= trim_abnormal;
         end
      end else begin
         trim_read <= 1'b0;
      end
      if (!rst_n) begin
         trim_latched <= {`RWS_TRIM_W{1'b0}};
         trim_bad     <= 1'b0;
      end
   end

   always @(posedge clk) begin
      cpu_reset    <= (next_state != ST_RUN);
      periph_reset <= (next_state != ST_RUN);
      cpu_run      <= (next_state == ST_RUN);
      watchdog_enable <= (next_state == ST_RUN);
      if (next_state != ST_RUN) begin
         program_counter <= serial_prog_mode ? `RWS_PC_SERIAL : `RWS_PC_MCU;
         stack_pointer   <= `RWS_SP_RESET;
         register_bank_selector  <= `RWS_RBS_RESET;
         interrupt_master_enable <= `RWS_IMF_RESET;
      end
      individual_interrupt_enables_clear <= (next_state != ST_RUN);
      interrupt_request_latches_clear    <= (next_state != ST_RUN);
      high_freq_osc_enable <= 1'b1;
      low_freq_osc_enable  <= 1'b0;
      prescaler_clear      <= (next_state != ST_RUN);
      port_hiz             <= (next_state != ST_RUN);
   end

   // Cause flags and detector disable: set beats software clear in the same cycle.
   always @(posedge clk) begin
      if (!rst_n || ext_reset) begin
         reset_cause_flags <= {NINT{1'b0}};
         vd_kill           <= 1'b1;
      end else begin
         if (access && avs_write && avs_address == `RWS_ADDR_CAUSE && avs_writedata[0])
            reset_cause_flags <= sync_src[NINT+1:2];
         else
            reset_cause_flags <= reset_cause_flags | sync_src[NINT+1:2];
         if (access && avs_write && avs_address == `RWS_ADDR_CTRL)
            vd_kill <= avs_writedata[0];
      end
      voltage_detect_disable <= vd_kill;
   end

   // One wait state per access; request is taken on the second edge.
   assign access          = (avs_read | avs_write) & acked;
   assign avs_waitrequest = (avs_read | avs_write) & ~acked;

   always @(posedge clk) begin
      if (!rst_n) begin
         acked        <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         acked <= (avs_read | avs_write) & ~acked;
         if ((avs_read | avs_write) & ~acked) begin
            case (avs_address)
               `RWS_ADDR_CTRL:   avs_readdata <= {31'h00000000, vd_kill};
               `RWS_ADDR_STATUS: avs_readdata <= {27'h0000000, trim_bad, trim_done,
                                                  watchdog_enable, state};
               `RWS_ADDR_CAUSE:  avs_readdata <= {{(32-NINT){1'b0}}, reset_cause_flags};
               `RWS_ADDR_TRIM:   avs_readdata <= {24'h000000, trim_latched};
               `RWS_ADDR_WARMUP: avs_readdata <= WARMUP_CYC;
               default:          avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [rws_seq_sva.sv]
// Port checker for the reset and warm-up sequencer.
// Assumes one clock and a bind onto rws_sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "rws_consts.vh"
module rws_seq_sva #(
   parameter        NINT       = 5,
   parameter [31:0] WARMUP_CYC = 32'h8
) (
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            por_req,
   input wire logic [NINT-1:0] internal_req,
   input wire logic            serial_prog_mode,
   input wire logic            trim_read,
   input wire logic            cpu_reset,
   input wire logic            periph_reset,
   input wire logic            cpu_run,
   input wire logic [15:0]     program_counter,
   input wire logic [15:0]     stack_pointer,
   input wire logic [3:0]      register_bank_selector,
   input wire logic            prescaler_clear,
   input wire logic            port_hiz,
   input wire logic            watchdog_enable
);
   logic [31:0] cnt;
   // Counts from the last source edge; the synchroniser only makes real warm-up longer.
   always @(posedge clk) cnt <= (!rst_n || por_req || |internal_req) ? 32'h0 : cnt + 32'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      !cpu_run ##1 cpu_run;
   endsequence
   chk_source_resets: assert property ($rose(por_req) || $rose(|internal_req) |-> ##[1:4] cpu_reset)
      else $error("source did not reset");
   chk_reset_holds: assert property (cpu_reset |-> periph_reset && !cpu_run)
      else $error("run during reset");
   chk_warmup_len: assert property (s_start |-> cnt >= WARMUP_CYC)
      else $error("warm-up too short");
   chk_trim_done: assert property (cpu_run |-> !trim_read)
      else $error("trim read after warm-up");
   chk_vector_pc: assert property (s_start |-> program_counter == (serial_prog_mode ?
      `RWS_PC_SERIAL : `RWS_PC_MCU)) else $error("wrong start vector");
   chk_stack_init: assert property (cpu_reset |-> stack_pointer == `RWS_SP_RESET &&
      register_bank_selector == `RWS_RBS_RESET) else $error("cpu state not reset");
   chk_timer_hiz: assert property (cpu_reset |-> prescaler_clear && port_hiz)
      else $error("prescaler or ports active");
   chk_wdog_run: assert property (watchdog_enable == cpu_run)
      else $error("watchdog out of step");
endmodule
bind rws_sequencer rws_seq_sva #(.NINT(NINT), .WARMUP_CYC(WARMUP_CYC)) u_sva (.*);
`default_nettype wire

// [rws_trim_store.sv]
// Trim store model: answers a held read some cycles later with one valid pulse.
// Assumes the sequencer holds trim_read until it has the data.
`timescale 1ns/1ps
`default_nettype none
module rws_trim_store #(
   parameter       DLY  = 3,
   parameter [7:0] TRIM = 8'h5a
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       trim_read,
   output var  logic       trim_valid,
   output var  logic [7:0] trim_data,
   output var  logic       trim_abnormal
);
   logic [3:0] n;
   always @(posedge clk) begin
      n <= (!rst_n || !trim_read) ? 4'h0 : n + 4'h1;
      trim_valid <= rst_n && trim_read && n == DLY;
      // Outside the answer the data toggles so a stale latch shows.
      trim_data <= (!rst_n || (trim_read && n == DLY)) ? TRIM : ~trim_data;
      trim_abnormal <= 1'b0;
   end
endmodule
`default_nettype wire

// [rws_sequencer_tb_top.sv]
// Testbench for the reset and warm-up sequencer.
// Assumes the trim store model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "rws_consts.vh"
module rws_sequencer_tb_top;
   localparam W = 8;
   logic clk, rst_n, por_req, pin_reset_n, pin_reset_disable, serial_prog_mode, trim_read;
   logic trim_valid, trim_abnormal, trim_bad, cpu_reset, periph_reset, cpu_run;
   logic interrupt_master_enable, individual_interrupt_enables_clear, port_hiz;
   logic interrupt_request_latches_clear, high_freq_osc_enable, low_freq_osc_enable;
   logic prescaler_clear, watchdog_enable, voltage_detect_disable;
   logic avs_read, avs_write, avs_waitrequest;
   logic [2:0] avs_address;
   logic [4:0] internal_req, reset_cause_flags;
   logic [7:0] trim_data, trim_latched;
   logic [3:0] register_bank_selector;
   logic [15:0] program_counter, stack_pointer;
   logic [31:0] avs_writedata, avs_readdata, q;
   int num_errors = 0, n_checks = 0;
   rws_sequencer #(.WARMUP_CYC(W)) dut (.*);
   rws_trim_store mdl (.*);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // The request stands until an edge samples waitrequest low; data is taken there.
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clk);
      internal_req <= v;
      @(posedge clk);
      internal_req <= 5'h0;
   endtask
   task automatic run_up;
      repeat (64) if (cpu_run !== 1'b1) @(posedge clk);
      chk(cpu_run, 1'b1);
   endtask
   task automatic t_boot;
      run_up();
      chk(program_counter, `RWS_PC_MCU);
      chk(stack_pointer, `RWS_SP_RESET);
      chk(trim_latched, 8'h5a);
      chk(watchdog_enable, 1'b1);
      chk(trim_bad, 1'b0);
      chk(cpu_reset, 1'b0);
      chk(interrupt_master_enable, `RWS_IMF_RESET);
      chk(high_freq_osc_enable, 1'b1);
      chk(low_freq_osc_enable, 1'b0);
      bus(3'h7, 1'b0, 32'h0);
      chk(q, 32'h0);
      $display("boot done");
   endtask
   task automatic t_internal;
      bus(`RWS_ADDR_CTRL, 1'b1, 32'h0);
      for (int k = 0; k < 5; k++) begin
         pulse(5'h1 << k);
         repeat (4) @(posedge clk);
         chk(cpu_reset, 1'b1);
         run_up();
         chk(reset_cause_flags, (32'h2 << k) - 32'h1);
         chk(voltage_detect_disable, 1'b0);
      end
      $display("internal done");
   endtask
   task automatic t_ext(input logic por);
      bus(`RWS_ADDR_CTRL, 1'b1, 32'h0);
      por_req <= por;
      pin_reset_n <= por;
      repeat (4) @(posedge clk);
      por_req <= 1'b0;
      pin_reset_n <= 1'b1;
      run_up();
      chk(reset_cause_flags, 5'h0);
      chk(voltage_detect_disable, 1'b1);
      $display("external done");
   endtask
   task automatic t_restart;
      serial_prog_mode <= 1'b1;
      pulse(5'h01);
      // The second request must land inside warm-up, well before it could end.
      repeat (W / 2) @(posedge clk);
      chk(program_counter, `RWS_PC_SERIAL);
      chk(port_hiz, 1'b1);
      chk(prescaler_clear, 1'b1);
      pulse(5'h01);
      repeat (W) @(posedge clk);
      chk(cpu_run, 1'b0);
      run_up();
      chk(program_counter, `RWS_PC_SERIAL);
      bus(`RWS_ADDR_CAUSE, 1'b1, 32'h1);
      bus(`RWS_ADDR_CAUSE, 1'b0, 32'h0);
      chk(q, 32'h0);
      serial_prog_mode <= 1'b0;
      $display("restart done");
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, por_req, pin_reset_disable, serial_prog_mode, avs_read, avs_write} = 6'h0;
      {pin_reset_n, internal_req, avs_address, avs_writedata} = {1'b1, 40'h0};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_boot();
      t_internal();
      t_ext(1'b1);
      t_restart();
      t_ext(1'b0);
      end_of_test();
   end
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
